/* File: include/gscm_pkg.sv */
// constants for the gauge standard command map
package gscm_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_LOAD_RATE = 8'h02;
  localparam logic [7:0] OFS_RAW_CHARGE = 8'h04;
  localparam logic [7:0] OFS_TEMPERATURE = 8'h06;
  localparam logic [7:0] OFS_VOLTAGE = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0A;
  localparam logic [7:0] OFS_UNCOMP_REM = 8'h0C;
  localparam logic [7:0] OFS_UNCOMP_FULL = 8'h0E;
  localparam logic [7:0] OFS_SEL_REM = 8'h10;
  localparam logic [7:0] OFS_SEL_FULL = 8'h12;
  localparam logic [7:0] OFS_MEAN_CUR = 8'h14;
  localparam logic [7:0] OFS_RUNTIME = 8'h16;
  localparam logic [7:0] OFS_SMOOTH_FULL = 8'h18;
  localparam logic [7:0] OFS_PROTECT = 8'h1A;
  localparam logic [7:0] OFS_COMP_FULL = 8'h1C;
  localparam logic [7:0] OFS_PEAK_CUR = 8'h1E;
  localparam logic [7:0] OFS_COMP_REM = 8'h20;
  localparam logic [7:0] OFS_SMOOTH_REM = 8'h22;
  localparam logic [7:0] OFS_LAST = 8'h23;
  localparam logic [15:0] SUB_PEAK_INT_CLEAR = 16'h0023;
  localparam logic [15:0] SUB_CAL_TOGGLE = 16'h002D;
  localparam logic [15:0] SUB_FULL_RESET = 16'h0041;
  localparam logic [15:0] SUB_RAW_START = 16'h0080;
  localparam logic [15:0] SUB_RAW_STOP = 16'h0081;
  localparam logic [15:0] SUB_OFFSET_CAL = 16'h0082;
  // status word bit positions
  localparam int ST_BAT_HIGH = 13;
  localparam int ST_BAT_LOW = 12;
  localparam int ST_CHG_INHIBIT = 11;
  localparam int ST_FULL_CHARGE = 9;
  localparam int ST_CHG_SUSPEND = 7;
  localparam int ST_PEAK_CHANGE = 4;
  localparam int ST_CHG_ALLOWED = 3;
  localparam int ST_FIRST_THR = 2;
  localparam int ST_FINAL_THR = 1;
  localparam int ST_DISCHARGING = 0;
  // protection word bit positions
  localparam int PR_INTERNAL_SHORT = 5;
  localparam int PR_TAB_DISCONNECT = 4;
  localparam int PR_OVERTEMP_CHG = 3;
  localparam int PR_OVERTEMP_DSG = 2;
  localparam logic [15:0] RST_LOAD_RATE = 16'h0000;
  localparam logic [15:0] RST_CONTROL = 16'h0000;
  localparam logic [15:0] SOC_MAX = 16'h0064;
  localparam logic [15:0] VOLT_MAX = 16'h1770;
  localparam logic [15:0] TTE_IDLE = 16'hFFFF;
  localparam logic [15:0] FC_THR_OFF = 16'hFFFF;
  // average current refresh periods
  localparam int CLK_HZ = 125000000;
  localparam int AVG_NORMAL_S = 1;
  localparam int AVG_SLEEP_S = 20;
  localparam int AVG_NORMAL_CYC = CLK_HZ * AVG_NORMAL_S;
  localparam longint AVG_SLEEP_CYC = longint'(CLK_HZ) * AVG_SLEEP_S;
endpackage : gscm_pkg

/* File: verilog/gscm_command_map.sv */
// standard command register map of the gauge with its subcommand decoder
// How it works
// - 0x0023 clears peak-current interrupt when enabled
// - 0x002D toggles calibration mode
// - 0x0041 full reset only while unlocked
// - 0x0080 starts, 0x0081 stops raw collection
// - 0x0082 offset calibration only in calibration
// - load-rate word signed, units per load model
// - 0x04 raw charge percent clamped 0..100
// - 0x06 temperature from sensor per source bit
// - 0x08 pack voltage in mV, 0..6000
// - status high byte: bits 5,4,3,1
// - status low byte: bits 7,4,3,2,1,0
// - charge inhibit/suspend from temperature limits
// - full-charge flag from termination or threshold
// - 0x10/0x12 follow filter select bit
// - mean current refresh 1 s or 20 s
// - runtime reads 65535 when not discharging
// - protection word low byte bits 5..2
// - 0x0C/0x0E uncompensated capacities in mAh
// - 0x20/0x22 compensated raw and filtered remaining
// - 0x18 smoothed full capacity; host reads 0x1C
// - 0x1E peak sustainable discharge current
// - subcommand results readable at 0x00/0x01
module gscm_command_map
  import gscm_pkg::*;
#(
  parameter longint AVG_SLEEP_CYCLES = gscm_pkg::AVG_SLEEP_CYC,
  parameter int AVG_NORMAL_CYCLES = gscm_pkg::AVG_NORMAL_CYC
)(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [gscm_pkg::ADDR_W-1:0] addr_i,
  input wire logic wr_en_i,
  input wire logic [7:0] wr_data_i,
  input wire logic rd_en_i,
  output logic [7:0] rd_data_o,
  input wire logic unlocked_i,
  input wire logic peak_current_feature_enable_i,
  input wire logic filter_select_bit_i,
  input wire logic temp_source_select_i,
  input wire logic sleep_mode_i,
  input wire logic load_model_i,
  input wire logic [15:0] raw_charge_i,
  input wire logic [15:0] internal_temp_i,
  input wire logic [15:0] thermistor_temp_i,
  input wire logic [15:0] voltage_i,
  input wire logic [15:0] current_i,
  input wire logic [15:0] runtime_i,
  input wire logic [15:0] uncomp_rem_i,
  input wire logic [15:0] uncomp_full_i,
  input wire logic [15:0] comp_rem_i,
  input wire logic [15:0] comp_full_i,
  input wire logic [15:0] smooth_rem_i,
  input wire logic [15:0] smooth_full_i,
  input wire logic [15:0] peak_current_i,
  input wire logic [15:0] temp_limit1_i,
  input wire logic [15:0] temp_limit4_i,
  input wire logic [15:0] temp_limit5_i,
  input wire logic charging_i,
  input wire logic charge_term_i,
  input wire logic [15:0] full_charge_set_threshold_i,
  input wire logic [15:0] state_of_charge_i,
  input wire logic battery_high_flag_i,
  input wire logic battery_low_flag_i,
  input wire logic peak_change_i,
  input wire logic fast_charge_allowed_flag_i,
  input wire logic first_threshold_flag_i,
  input wire logic final_threshold_flag_i,
  input wire logic discharging_flag_i,
  input wire logic internal_short_fault_i,
  input wire logic tab_disconnect_fault_i,
  input wire logic overtemp_charge_fault_i,
  input wire logic overtemp_discharge_fault_i,
  input wire logic [15:0] sub_result_i,
  output logic peak_interrupt_o,
  output logic calibration_active_bit_o,
  output logic raw_collect_o,
  output logic offset_cal_start_o,
  output logic full_reset_o,
  output logic load_model_o,
  output logic [15:0] load_rate_setpoint_o
);
  import gscm_pkg::*;

  typedef struct packed {
    logic [15:0] control;
    logic [15:0] load_rate;
    logic [15:0] mean_cur;
    logic [31:0] avg_cnt;
    logic peak_int;
    logic peak_change_d;
    logic cal_active;
    logic raw_collect;
    logic offset_cal;
    logic full_reset;
    logic [7:0] rd_data;
  } gscm_state_t;

  gscm_state_t state_reg;
  gscm_state_t state_next;

  // clamp to an upper bound
  function automatic logic [15:0] gscm_clamp(input logic [15:0] v, input logic [15:0] lim);
    gscm_clamp = (v > lim) ? lim : v;
  endfunction : gscm_clamp

  // a change event counts only on its rising edge
  function automatic logic gscm_rise(input logic now_v, input logic before_v);
    gscm_rise = now_v && !before_v;
  endfunction : gscm_rise

  logic [15:0] temperature;
  logic [15:0] status_word;
  logic [15:0] protect_word;
  logic charge_inhibit_flag;
  logic charge_suspend_flag;
  logic full_charge_flag;
  logic [15:0] word_sel;
  logic [31:0] avg_period;
  logic [15:0] sub_code;
  logic peak_event;

  always_comb
  begin
    if (temp_source_select_i)
    begin
      temperature = thermistor_temp_i;
    end
    else
    begin
      temperature = internal_temp_i;
    end
    charge_inhibit_flag = !charging_i && ((temperature < temp_limit1_i) ||
      (temperature > temp_limit4_i));
    charge_suspend_flag = charging_i && ((temperature < temp_limit1_i) ||
      (temperature > temp_limit5_i));
    if (full_charge_set_threshold_i == FC_THR_OFF)
    begin
      full_charge_flag = charge_term_i;
    end
    else
    begin
      full_charge_flag = state_of_charge_i > full_charge_set_threshold_i;
    end
  end

  always_comb
  begin
    // reserved bits read as zero
    status_word = 16'h0000;
    status_word[ST_BAT_HIGH] = battery_high_flag_i;
    status_word[ST_BAT_LOW] = battery_low_flag_i;
    status_word[ST_CHG_INHIBIT] = charge_inhibit_flag;
    status_word[ST_FULL_CHARGE] = full_charge_flag;
    status_word[ST_CHG_SUSPEND] = charge_suspend_flag;
    status_word[ST_PEAK_CHANGE] = peak_change_i;
    status_word[ST_CHG_ALLOWED] = fast_charge_allowed_flag_i;
    status_word[ST_FIRST_THR] = first_threshold_flag_i;
    status_word[ST_FINAL_THR] = final_threshold_flag_i;
    status_word[ST_DISCHARGING] = discharging_flag_i;
  end

  always_comb
  begin
    protect_word = 16'h0000;
    protect_word[PR_INTERNAL_SHORT] = internal_short_fault_i;
    protect_word[PR_TAB_DISCONNECT] = tab_disconnect_fault_i;
    protect_word[PR_OVERTEMP_CHG] = overtemp_charge_fault_i;
    protect_word[PR_OVERTEMP_DSG] = overtemp_discharge_fault_i;
  end

  // word picked by the even address of the pair
  always_comb
  begin
    unique case ({addr_i[7:1], 1'b0})
      OFS_CONTROL:
      begin
        word_sel = state_reg.control;
      end
      OFS_LOAD_RATE:
      begin
        word_sel = state_reg.load_rate;
      end
      OFS_RAW_CHARGE:
      begin
        word_sel = gscm_clamp(raw_charge_i, SOC_MAX);
      end
      OFS_TEMPERATURE:
      begin
        word_sel = temperature;
      end
      OFS_VOLTAGE:
      begin
        word_sel = gscm_clamp(voltage_i, VOLT_MAX);
      end
      OFS_STATUS:
      begin
        word_sel = status_word;
      end
      OFS_UNCOMP_REM:
      begin
        word_sel = uncomp_rem_i;
      end
      OFS_UNCOMP_FULL:
      begin
        word_sel = uncomp_full_i;
      end
      OFS_SEL_REM:
      begin
        word_sel = filter_select_bit_i ? smooth_rem_i : comp_rem_i;
      end
      OFS_SEL_FULL:
      begin
        word_sel = filter_select_bit_i ? smooth_full_i : comp_full_i;
      end
      OFS_MEAN_CUR:
      begin
        word_sel = state_reg.mean_cur;
      end
      OFS_RUNTIME:
      begin
        if (discharging_flag_i)
        begin
          word_sel = runtime_i;
        end
        else
        begin
          word_sel = TTE_IDLE;
        end
      end
      OFS_SMOOTH_FULL:
      begin
        word_sel = smooth_full_i;
      end
      OFS_PROTECT:
      begin
        word_sel = protect_word;
      end
      OFS_COMP_FULL:
      begin
        word_sel = comp_full_i;
      end
      OFS_PEAK_CUR:
      begin
        word_sel = peak_current_i;
      end
      OFS_COMP_REM:
      begin
        word_sel = comp_rem_i;
      end
      OFS_SMOOTH_REM:
      begin
        word_sel = smooth_rem_i;
      end
      default:
      begin
        word_sel = 16'h0000;
      end
    endcase
  end

  always_comb
  begin
    state_next = state_reg;
    state_next.offset_cal = 1'b0;
    state_next.full_reset = 1'b0;
    state_next.peak_change_d = peak_change_i;
    avg_period = sleep_mode_i ? 32'(AVG_SLEEP_CYCLES) : 32'(AVG_NORMAL_CYCLES);
    sub_code = {wr_data_i, state_reg.control[7:0]};
    peak_event = gscm_rise(peak_change_i, state_reg.peak_change_d);
    // peak interrupt raised on a new change event
    if (peak_current_feature_enable_i && peak_event)
    begin
      state_next.peak_int = 1'b1;
    end
    // average current sampled once per refresh period
    if (state_reg.avg_cnt >= avg_period - 32'd1)
    begin
      state_next.avg_cnt = 32'd0;
      state_next.mean_cur = current_i;
    end
    else
    begin
      state_next.avg_cnt = state_reg.avg_cnt + 32'd1;
    end
    if (rd_en_i)
    begin
      if (addr_i[0])
      begin
        state_next.rd_data = word_sel[15:8];
      end
      else
      begin
        state_next.rd_data = word_sel[7:0];
      end
    end
    if (wr_en_i)
    begin
      unique case (addr_i)
        OFS_CONTROL:
        begin
          state_next.control[7:0] = wr_data_i;
        end
        OFS_CONTROL + 8'h01:
        begin
          // a high-byte write completes the subcommand
          state_next.control = sub_result_i;
          unique case (sub_code)
            SUB_PEAK_INT_CLEAR:
            begin
              // a new event in the same cycle wins over the clear
              if (peak_current_feature_enable_i && !peak_event)
              begin
                state_next.peak_int = 1'b0;
              end
            end
            SUB_CAL_TOGGLE:
            begin
              state_next.cal_active = !state_reg.cal_active;
            end
            SUB_FULL_RESET:
            begin
              state_next.full_reset = unlocked_i;
            end
            SUB_RAW_START:
            begin
              state_next.raw_collect = 1'b1;
            end
            SUB_RAW_STOP:
            begin
              state_next.raw_collect = 1'b0;
            end
            SUB_OFFSET_CAL:
            begin
              state_next.offset_cal = state_reg.cal_active;
            end
            default:
            begin
              state_next.control = sub_result_i;
            end
          endcase
        end
        OFS_LOAD_RATE:
        begin
          state_next.load_rate[7:0] = wr_data_i;
        end
        OFS_LOAD_RATE + 8'h01:
        begin
          state_next.load_rate[15:8] = wr_data_i;
        end
        default:
        begin
          // read-only pairs ignore writes
          state_next.rd_data = state_next.rd_data;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i || state_reg.full_reset)
    begin
      state_reg <= '0;
      state_reg.control <= RST_CONTROL;
      state_reg.load_rate <= RST_LOAD_RATE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign rd_data_o = state_reg.rd_data;
  assign peak_interrupt_o = state_reg.peak_int;
  assign calibration_active_bit_o = state_reg.cal_active;
  assign raw_collect_o = state_reg.raw_collect;
  assign offset_cal_start_o = state_reg.offset_cal;
  assign full_reset_o = state_reg.full_reset;
  assign load_model_o = load_model_i;
  assign load_rate_setpoint_o = state_reg.load_rate;
endmodule : gscm_command_map

/* File: verif/gscm_chk.sv */
// assertions on the command map ports
module gscm_chk
  import gscm_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [gscm_pkg::ADDR_W-1:0] addr_i,
  input wire logic wr_en_i,
  input wire logic [7:0] wr_data_i,
  input wire logic rd_en_i,
  input wire logic [7:0] rd_data_o,
  input wire logic unlocked_i,
  input wire logic peak_current_feature_enable_i,
  input wire logic peak_change_i,
  input wire logic [15:0] voltage_i,
  input wire logic peak_interrupt_o,
  input wire logic calibration_active_bit_o,
  input wire logic raw_collect_o,
  input wire logic offset_cal_start_o,
  input wire logic full_reset_o,
  input wire logic [15:0] load_rate_setpoint_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lo_q;
  logic [15:0] cmd;
  logic hit;
  logic [15:0] vc;
  // subcommand is complete when its high byte lands
  assign cmd = {wr_data_i, lo_q};
  assign hit = wr_en_i && addr_i == 8'h01;
  assign vc = (voltage_i > VOLT_MAX) ? VOLT_MAX : voltage_i;
  always_ff @(posedge clock_i)
  begin
    if (wr_en_i && addr_i == OFS_CONTROL)
      lo_q <= wr_data_i;
  end
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);
  AST_CAL_TOGGLE: assert property (
    hit && cmd == SUB_CAL_TOGGLE |=> calibration_active_bit_o != $past(calibration_active_bit_o))
    else $error("cal toggle");
  AST_RESET_LOCKED: assert property (
    hit && cmd == SUB_FULL_RESET && !unlocked_i |=> !full_reset_o ##1 !full_reset_o)
    else $error("locked reset");
  AST_RESET_DONE: assert property (
    hit && cmd == SUB_FULL_RESET && unlocked_i |=> full_reset_o ##1
    (!calibration_active_bit_o && load_rate_setpoint_o == RST_LOAD_RATE))
    else $error("full reset");
  AST_RAW_COLLECT: assert property (
    hit && (cmd == SUB_RAW_START || cmd == SUB_RAW_STOP) |=> raw_collect_o == !$past(lo_q[0]))
    else $error("raw collect");
  AST_OFFSET_CAL: assert property (
    hit && cmd == SUB_OFFSET_CAL |=> offset_cal_start_o == $past(calibration_active_bit_o))
    else $error("offset cal");
  AST_PEAK_CLEAR: assert property (
    hit && cmd == SUB_PEAK_INT_CLEAR && peak_current_feature_enable_i && !peak_change_i
    |=> !peak_interrupt_o)
    else $error("peak clear");
  AST_VOLT_READ: assert property (
    rd_en_i && addr_i == OFS_VOLTAGE |=> rd_data_o == $past(vc[7:0]))
    else $error("voltage read");
  AST_RATE_HIGH: assert property (
    wr_en_i && addr_i == 8'h03 |=> load_rate_setpoint_o[15:8] == $past(wr_data_i))
    else $error("rate high byte");
endmodule : gscm_chk

bind gscm_command_map gscm_chk u_chk (.clock_i, .rst_b_i, .addr_i, .wr_en_i, .wr_data_i,
  .rd_en_i, .rd_data_o, .unlocked_i, .peak_current_feature_enable_i, .peak_change_i,
  .voltage_i, .peak_interrupt_o, .calibration_active_bit_o, .raw_collect_o,
  .offset_cal_start_o, .full_reset_o, .load_rate_setpoint_o);

/* File: verif/gscm_host_model.sv */
// host side of the byte-wide command link
module gscm_host_model (
  input wire logic clock_i,
  output logic [7:0] addr_o,
  output logic wr_en_o,
  output logic [7:0] wr_data_o,
  output logic rd_en_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    addr_o = 8'hFF;
    wr_en_o = 1'b0;
    wr_data_o = 8'h00;
    rd_en_o = 1'b0;
  end
  // released address and data lines show the inverse of the last value; both enables drop low
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(negedge clock_i);
    addr_o = a;
    wr_data_o = d;
    wr_en_o = w;
    rd_en_o = !w;
    @(negedge clock_i);
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = ~a;
    wr_data_o = ~d;
  endtask : xfer
endmodule : gscm_host_model

/* File: verif/testbench.sv */
// self-checking bench for the gauge standard command map
module testbench
  import gscm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] addr_i, wr_data_i, rd_data_o;
  logic wr_en_i, rd_en_i, peak_interrupt_o, calibration_active_bit_o, raw_collect_o;
  logic offset_cal_start_o, full_reset_o, load_model_o, rd_seen = 1'b0;
  logic unlocked_i = 1'b0, peak_current_feature_enable_i = 1'b0, peak_change_i = 1'b0;
  logic [15:0] load_rate_setpoint_o, lr = 16'h0000, ctl = 16'h0000, f = 16'h0000;
  logic [15:0] w [19];
  logic [7:0] exq [$];
  int seed = 67, mismatches = 0, comparisons = 0;
  gscm_command_map #(.AVG_SLEEP_CYCLES(20), .AVG_NORMAL_CYCLES(4)) u_dut (
    .clock_i, .rst_b_i, .addr_i, .wr_en_i, .wr_data_i, .rd_en_i, .rd_data_o, .unlocked_i,
    .peak_current_feature_enable_i, .filter_select_bit_i(f[0]), .temp_source_select_i(f[1]),
    .sleep_mode_i(f[2]), .load_model_i(f[3]), .raw_charge_i(w[0]), .internal_temp_i(w[1]),
    .thermistor_temp_i(w[2]), .voltage_i(w[3]), .current_i(w[4]), .runtime_i(w[5]),
    .uncomp_rem_i(w[6]), .uncomp_full_i(w[7]), .comp_rem_i(w[8]), .comp_full_i(w[9]),
    .smooth_rem_i(w[10]), .smooth_full_i(w[11]), .peak_current_i(w[12]),
    .temp_limit1_i(w[13]), .temp_limit4_i(w[14]), .temp_limit5_i(w[15]),
    .charging_i(f[4]), .charge_term_i(f[5]), .full_charge_set_threshold_i(w[16]),
    .state_of_charge_i(w[17]), .battery_high_flag_i(f[6]), .battery_low_flag_i(f[7]),
    .peak_change_i, .fast_charge_allowed_flag_i(f[8]), .first_threshold_flag_i(f[9]),
    .final_threshold_flag_i(f[10]), .discharging_flag_i(f[11]),
    .internal_short_fault_i(f[12]), .tab_disconnect_fault_i(f[13]),
    .overtemp_charge_fault_i(f[14]), .overtemp_discharge_fault_i(f[15]),
    .sub_result_i(w[18]), .peak_interrupt_o, .calibration_active_bit_o, .raw_collect_o,
    .offset_cal_start_o, .full_reset_o, .load_model_o, .load_rate_setpoint_o);
  gscm_host_model u_host (.clock_i, .addr_o(addr_i), .wr_en_o(wr_en_i),
    .wr_data_o(wr_data_i), .rd_en_o(rd_en_i));
  initial
  begin
    forever #4 clock_i = ~clock_i;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic print_verdict();
    if (mismatches == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict
  function automatic logic [15:0] ew(input logic [7:0] a);
    logic [15:0] t;
    logic fc;
    t = f[1] ? w[2] : w[1];
    fc = (f[5] && w[16] == FC_THR_OFF) || (w[16] != FC_THR_OFF && w[17] > w[16]);
    case (a)
      8'h00: return ctl;
      8'h02: return lr;
      8'h04: return (w[0] > SOC_MAX) ? SOC_MAX : w[0];
      8'h06: return t;
      8'h08: return (w[3] > VOLT_MAX) ? VOLT_MAX : w[3];
      8'h0A: return {2'b00, f[6], f[7], !f[4] && (t < w[13] || t > w[14]), 1'b0, fc, 1'b0,
        f[4] && (t < w[13] || t > w[15]), 2'b00, peak_change_i, f[8], f[9], f[10], f[11]};
      8'h0C: return w[6];
      8'h0E: return w[7];
      8'h10: return f[0] ? w[10] : w[8];
      8'h12: return f[0] ? w[11] : w[9];
      8'h14: return w[4];
      8'h16: return f[11] ? w[5] : TTE_IDLE;
      8'h18: return w[11];
      8'h1A: return {10'h000, f[12], f[13], f[14], f[15], 2'b00};
      8'h1C: return w[9];
      8'h1E: return w[12];
      8'h20: return w[8];
      8'h22: return w[10];
      default: return 16'h0000;
    endcase
  endfunction : ew
  task automatic rdb(input logic [7:0] a);
    logic [15:0] e;
    e = ew({a[7:1], 1'b0});
    exq.push_back(a[0] ? e[15:8] : e[7:0]);
    u_host.xfer(a, 8'h00, 1'b0);
  endtask : rdb
  task automatic sub(input logic [15:0] c);
    u_host.xfer(OFS_CONTROL, c[7:0], 1'b1);
    u_host.xfer(8'h01, c[15:8], 1'b1);
    ctl = w[18];
  endtask : sub
  always @(posedge clock_i)
    rd_seen <= rd_en_i;
  always @(negedge clock_i)
    if (rd_seen)
      chk("rd_data", exq.pop_front(), rd_data_o);
  initial
  begin
    repeat (4000) @(posedge clock_i);
    mismatches++;
    print_verdict();
  end
  initial
  begin
    foreach (w[i])
      w[i] = 16'h0000;
    repeat (16) @(negedge clock_i);
    rst_b_i = 1'b1;
    rdb(OFS_LOAD_RATE);
    repeat (6)
    begin
      f = $random(seed);
      foreach (w[i])
        w[i] = $random(seed);
      w[0] &= 16'h007F;
      w[3] &= 16'h1FFF;
      w[17] &= 16'h007F;
      w[16] = f[2] ? FC_THR_OFF : (w[16] & 16'h007F);
      lr = $random(seed);
      u_host.xfer(OFS_LOAD_RATE, lr[7:0], 1'b1);
      u_host.xfer(8'h03, lr[15:8], 1'b1);
      u_host.xfer(OFS_VOLTAGE, 8'h5A, 1'b1);
      repeat (25) @(negedge clock_i);
      for (int a = 2; a < 36; a++)
        rdb(8'(a));
      rdb(8'h30);
      chk("model", {15'h0000, f[3]}, {15'h0000, load_model_o});
    end
    sub(SUB_CAL_TOGGLE);
    chk("cal_on", 16'h0001, {15'h0000, calibration_active_bit_o});
    rdb(OFS_CONTROL);
    rdb(8'h01);
    sub(SUB_OFFSET_CAL);
    sub(SUB_RAW_START);
    sub(SUB_RAW_STOP);
    sub(SUB_CAL_TOGGLE);
    sub(SUB_OFFSET_CAL);
    peak_current_feature_enable_i = 1'b1;
    peak_change_i = 1'b1;
    repeat (3) @(negedge clock_i);
    chk("peak_set", 16'h0001, {15'h0000, peak_interrupt_o});
    peak_change_i = 1'b0;
    peak_current_feature_enable_i = 1'b0;
    sub(SUB_PEAK_INT_CLEAR);
    chk("peak_kept", 16'h0001, {15'h0000, peak_interrupt_o});
    peak_current_feature_enable_i = 1'b1;
    sub(SUB_PEAK_INT_CLEAR);
    chk("peak_clr", 16'h0000, {15'h0000, peak_interrupt_o});
    sub(SUB_FULL_RESET);
    chk("locked", lr, load_rate_setpoint_o);
    unlocked_i = 1'b1;
    sub(SUB_FULL_RESET);
    @(negedge clock_i);
    chk("reset_rate", RST_LOAD_RATE, load_rate_setpoint_o);
    print_verdict();
  end
endmodule : testbench
